// ===== aic_pkg.sv
/*
  Constants for the add-on interrupt control/status block: register
  offsets, field positions and reset values.
  Assumes byte offsets on the add-on register port, 32-bit words.
*/
package aic_pkg;

  // Register offsets on the add-on register port
  localparam logic [5:0] AIC_OFS_IRQ_CTRL_STATUS = 6'h38;
  localparam logic [5:0] AIC_OFS_GENERAL_CTRL    = 6'h3c;

  // Field positions in addon_irq_ctrl_status
  localparam int AIC_B_SUMMARY   = 23;
  localparam int AIC_B_ABORT     = 21;
  localparam int AIC_B_SELFTEST  = 20;
  localparam int AIC_B_RD_DONE   = 19;
  localparam int AIC_B_WR_DONE   = 18;
  localparam int AIC_B_OBOX      = 17;
  localparam int AIC_B_IBOX      = 16;
  localparam int AIC_B_EN_RD     = 15;
  localparam int AIC_B_EN_WR     = 14;
  localparam int AIC_B_EN_OBOX   = 12;
  localparam int AIC_B_OBOX_SEL  = 10;
  localparam int AIC_B_OBYTE_SEL = 8;
  localparam int AIC_B_EN_IBOX   = 4;
  localparam int AIC_B_IBOX_SEL  = 2;
  localparam int AIC_B_IBYTE_SEL = 0;

  // Sticky flags occupy bits 21:16, index 0 is bit 16
  localparam int AIC_FLAG_LSB = 16;
  localparam int AIC_FLAG_W   = 6;

  // Writable control bits of bits 15:0
  localparam logic [15:0] AIC_CTRL_MASK = 16'hdf1f;

  // Self-test completion code field in the general control register
  localparam int AIC_B_BIST_CODE = 0;
  localparam int AIC_BIST_CODE_W = 4;

  // Reset values
  localparam logic [15:0] AIC_RST_CTRL  = 16'h0000;
  localparam logic [5:0]  AIC_RST_FLAGS = 6'h00;
  localparam logic [15:0] AIC_RST_FULL  = 16'h0000;

endpackage : aic_pkg

// ===== aic_ctrl.sv
/*
  Add-on interrupt control/status register with mailbox full flags and
  the self-test completion code hand-off.
  Assumes every input is synchronous to clk_i and every event input is
  a one-cycle pulse; the transfer-count zero inputs are levels.
*/
// Operation
// RULE_01: Bit 23 reads as the OR of all pending condition flags; the code ORs only enabled flags, with abort and self-test always enabled.
// RULE_02: Master or target abort on own PCI cycle sets bit 21.
// RULE_03: Writing one clears a sticky flag; writing zero leaves it.
// RULE_04: PCI self-test start sets bit 20 until software clears it.
// RULE_05: Writing general control register passes self-test code to PCI.
// RULE_06: Master read count reaching zero sets bit 19.
// RULE_07: Master write count reaching zero sets bit 18.
// RULE_08: PCI read of selected outgoing mailbox byte sets bit 17.
// RULE_09: PCI write of selected incoming mailbox byte sets bit 16.
// RULE_10: Bit 15 enables interrupt from read count zero.
// RULE_11: Bit 14 enables interrupt from write count zero.
// RULE_12: Bit 12 enables interrupt from outgoing mailbox read.
// RULE_13: Bits 11:10 pick outgoing mailbox one to four.
// RULE_14: Bits 9:8 pick byte of outgoing mailbox.
// RULE_15: Bit 4 enables interrupt from incoming mailbox write.
// RULE_16: Bits 3:2 pick incoming mailbox one to four.
// RULE_17: Bits 1:0 pick byte of incoming mailbox.
// RULE_18: Mailbox byte full flag set by writer, cleared by reader.
// RULE_19: Reserved bits read zero and ignore writes.
// RULE_20: Interrupt output follows the summary flag.
`timescale 1ns/1ps
`default_nettype none

module aic_ctrl
  import aic_pkg::*;
(
  input  wire logic                                clk_i,
  input  wire logic                                rst_b_i,
  // Add-on register port
  input  wire logic                                reg_sel_i,
  input  wire logic [5:0]                          reg_adr_i,
  input  wire logic                                reg_wr_i,
  input  wire logic                                reg_rd_i,
  input  wire logic [3:0]                          reg_be_i,
  input  wire logic [31:0]                         reg_wdata_i,
  output logic      [31:0]                         reg_rdata_o,
  output logic                                     reg_rvalid_o,
  // PCI side mailbox events
  input  wire logic                                pci_ibox_wr_i,
  input  wire logic [1:0]                          pci_ibox_sel_i,
  input  wire logic [3:0]                          pci_ibox_be_i,
  input  wire logic                                pci_obox_rd_i,
  input  wire logic [1:0]                          pci_obox_sel_i,
  input  wire logic [3:0]                          pci_obox_be_i,
  // Add-on side mailbox events
  input  wire logic                                addon_ibox_rd_i,
  input  wire logic [1:0]                          addon_ibox_sel_i,
  input  wire logic [3:0]                          addon_ibox_be_i,
  input  wire logic                                addon_obox_wr_i,
  input  wire logic [1:0]                          addon_obox_sel_i,
  input  wire logic [3:0]                          addon_obox_be_i,
  // Other sources
  input  wire logic                                selftest_start_i,
  input  wire logic                                mrd_count_zero_i,
  input  wire logic                                mwr_count_zero_i,
  input  wire logic                                master_abort_i,
  input  wire logic                                target_abort_i,
  // Results
  output logic      [31:0]                         mbox_status_o,
  output logic      [aic_pkg::AIC_BIST_CODE_W-1:0] selftest_code_o,
  output logic                                     selftest_code_wr_o,
  output logic                                     addon_irq_o
);
  import aic_pkg::*;

  typedef struct packed {
    logic [15:0]                ctrl;
    logic [AIC_FLAG_W-1:0]      flags;
    logic [15:0]                in_full;
    logic [15:0]                out_full;
    logic                       rd_zero;
    logic                       wr_zero;
    logic [31:0]                rdata;
    logic                       rvalid;
    logic [AIC_BIST_CODE_W-1:0] code;
    logic                       code_wr;
  } aic_state_t;

  aic_state_t s_q;
  aic_state_t s_d;

  // Byte-enable mask spread over the 16 mailbox bytes
  function automatic logic [15:0] aic_byte_mask(
    input logic [1:0] box,
    input logic [3:0] be
  );
    logic [15:0] m;
    m = 16'h0000;
    m[{box, 2'b00} +: 4] = be;
    return m;
  endfunction : aic_byte_mask

  // One-hot position of a mailbox/byte selection
  function automatic logic [15:0] aic_pick(
    input logic [1:0] box,
    input logic [1:0] byte_sel
  );
    logic [15:0] m;
    m = 16'h0000;
    m[{box, byte_sel}] = 1'b1;
    return m;
  endfunction : aic_pick

  // Access strobe aimed at one register offset
  function automatic logic aic_hit(
    input logic       sel,
    input logic       strobe,
    input logic [5:0] adr,
    input logic [5:0] ofs
  );
    logic hit;
    hit = sel && strobe && (adr == ofs);
    return hit;
  endfunction : aic_hit

  // Level to event; only the 0 to 1 step counts as reaching zero
  function automatic logic aic_rise(
    input logic level,
    input logic last
  );
    logic edge_seen;
    edge_seen = level && !last;
    return edge_seen;
  endfunction : aic_rise

  // Mask of one side's access, or nothing while that side is idle
  function automatic logic [15:0] aic_access(
    input logic       strobe,
    input logic [1:0] box,
    input logic [3:0] be
  );
    logic [15:0] m;
    m = 16'h0000;
    if (strobe)
    begin
      m = aic_byte_mask(box, be);
    end
    return m;
  endfunction : aic_access

  // Set after clear, so a store in the emptying cycle is kept
  function automatic logic [15:0] aic_fill(
    input logic [15:0] full,
    input logic [15:0] clr,
    input logic [15:0] set
  );
    logic [15:0] nxt;
    nxt = (full & ~clr) | set;
    return nxt;
  endfunction : aic_fill

  // Control lanes 0 and 1; reserved positions never stored
  function automatic logic [15:0] aic_lanes(
    input logic [3:0] be
  );
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & AIC_CTRL_MASK;
    return m;
  endfunction : aic_lanes

  // Write-one-to-clear; only byte lane 2 carries the flags
  function automatic logic [AIC_FLAG_W-1:0] aic_w1c(
    input logic        wr,
    input logic        lane,
    input logic [31:0] data
  );
    logic [AIC_FLAG_W-1:0] c;
    c = '0;
    if (wr && lane)
    begin
      c = data[AIC_FLAG_LSB +: AIC_FLAG_W];
    end
    return c;
  endfunction : aic_w1c

  // Read data by offset; unmapped offsets read as zero
  function automatic logic [31:0] aic_rmux(
    input logic [5:0]  adr,
    input logic [31:0] word_in
  );
    logic [31:0] d;
    d = 32'h0000_0000;
    if (adr == AIC_OFS_IRQ_CTRL_STATUS)
    begin
      d = word_in;
    end
    return d;
  endfunction : aic_rmux

  // Interrupt-worthy flags; self-test and abort have no enable bit
  function automatic logic [AIC_FLAG_W-1:0] aic_gate(
    input logic [AIC_FLAG_W-1:0] flags,
    input logic [15:0]           ctrl
  );
    logic [AIC_FLAG_W-1:0] g;
    g    = flags;
    g[3] = flags[3] & ctrl[AIC_B_EN_RD]; // [RULE_10]
    g[2] = flags[2] & ctrl[AIC_B_EN_WR]; // [RULE_11]
    g[1] = flags[1] & ctrl[AIC_B_EN_OBOX]; // [RULE_12]
    g[0] = flags[0] & ctrl[AIC_B_EN_IBOX]; // [RULE_15]
    return g;
  endfunction : aic_gate

  // Register image; reserved 31:24, 22, 13 and 7:5 come out as zero
  function automatic logic [31:0] aic_word(
    input logic                  sum_in,
    input logic [AIC_FLAG_W-1:0] flags,
    input logic [15:0]           ctrl
  );
    logic [31:0] w;
    w = {8'h00, sum_in, 1'b0, flags, ctrl & AIC_CTRL_MASK}; // [RULE_19]
    return w;
  endfunction : aic_word

  logic        wr_irq;
  logic        wr_gen;
  logic        rd_hit;
  logic [5:0]  flag_clr;
  logic [5:0]  flag_set;
  logic [15:0] ctrl_wmask;
  logic [15:0] in_pick;
  logic [15:0] out_pick;
  logic [15:0] in_set;
  logic [15:0] out_set;
  logic [5:0]  enabled;
  logic        summary;
  logic [31:0] irq_word;
  logic        code_take;
  logic        ev_ibox;
  logic        ev_obox;
  logic        ev_wr_zero;
  logic        ev_rd_zero;
  logic        ev_test;
  logic        ev_abort;

  always_comb
  begin
    s_d     = s_q;
    wr_irq  = aic_hit(reg_sel_i, reg_wr_i, reg_adr_i,
                      AIC_OFS_IRQ_CTRL_STATUS);
    wr_gen  = aic_hit(reg_sel_i, reg_wr_i, reg_adr_i,
                      AIC_OFS_GENERAL_CTRL);
    rd_hit  = reg_sel_i && reg_rd_i;

    // Selected trigger bytes
    in_pick  = aic_pick(s_q.ctrl[AIC_B_IBOX_SEL +: 2],
                        s_q.ctrl[AIC_B_IBYTE_SEL +: 2]); // [RULE_16] [RULE_17]
    out_pick = aic_pick(s_q.ctrl[AIC_B_OBOX_SEL +: 2],
                        s_q.ctrl[AIC_B_OBYTE_SEL +: 2]); // [RULE_13] [RULE_14]

    in_set  = aic_access(pci_ibox_wr_i, pci_ibox_sel_i, pci_ibox_be_i);
    out_set = aic_access(pci_obox_rd_i, pci_obox_sel_i, pci_obox_be_i);

    // Event sources
    ev_ibox    = |(in_set & in_pick); // [RULE_09]
    ev_obox    = |(out_set & out_pick); // [RULE_08]
    ev_wr_zero = aic_rise(mwr_count_zero_i, s_q.wr_zero); // [RULE_07]
    ev_rd_zero = aic_rise(mrd_count_zero_i, s_q.rd_zero); // [RULE_06]
    ev_test    = selftest_start_i; // [RULE_04]
    ev_abort   = master_abort_i || target_abort_i; // [RULE_02]
    // Index 0 is bit 16
    flag_set   = {ev_abort,
                  ev_test,
                  ev_rd_zero,
                  ev_wr_zero,
                  ev_obox,
                  ev_ibox};
    s_d.rd_zero = mrd_count_zero_i;
    s_d.wr_zero = mwr_count_zero_i;

    // Write-one-to-clear on byte lane 2 only
    flag_clr = aic_w1c(wr_irq, reg_be_i[2], reg_wdata_i);
    // A new event in the clearing cycle survives
    s_d.flags = (s_q.flags & ~flag_clr) | flag_set; // [RULE_03]

    // Control bits, reserved positions never stored
    ctrl_wmask = aic_lanes(reg_be_i);
    if (wr_irq)
    begin
      s_d.ctrl = (s_q.ctrl & ~ctrl_wmask)
                 | (reg_wdata_i[15:0] & ctrl_wmask); // [RULE_19]
    end

    // Mailbox full flags; the writer's set wins over the reader's clear
    s_d.in_full  = aic_fill(s_q.in_full,
                            aic_access(addon_ibox_rd_i, addon_ibox_sel_i,
                                       addon_ibox_be_i),
                            in_set); // [RULE_18]
    s_d.out_full = aic_fill(s_q.out_full, out_set,
                            aic_access(addon_obox_wr_i, addon_obox_sel_i,
                                       addon_obox_be_i)); // [RULE_18]

    // Self-test completion code toward the PCI self-test register
    code_take   = wr_gen && reg_be_i[0];
    s_d.code_wr = code_take; // [RULE_05]
    if (code_take)
    begin
      s_d.code = reg_wdata_i[AIC_B_BIST_CODE +: AIC_BIST_CODE_W]; // [RULE_05]
    end

    // Read data holds until the next read
    s_d.rvalid = rd_hit;
    if (rd_hit)
    begin
      s_d.rdata = aic_rmux(reg_adr_i, irq_word);
    end
  end

  assign enabled = aic_gate(s_q.flags, s_q.ctrl);

  // Disabled flags stay visible but never raise the summary
  assign summary = |enabled; // [RULE_01]

  assign irq_word = aic_word(summary, s_q.flags, s_q.ctrl);

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      s_q          <= '0;
      s_q.ctrl     <= AIC_RST_CTRL;
      s_q.flags    <= AIC_RST_FLAGS;
      s_q.in_full  <= AIC_RST_FULL;
      s_q.out_full <= AIC_RST_FULL;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o        = s_q.rdata;
  assign reg_rvalid_o       = s_q.rvalid;
  assign mbox_status_o      = {s_q.out_full, s_q.in_full};
  assign selftest_code_o    = s_q.code;
  assign selftest_code_wr_o = s_q.code_wr;
  assign addon_irq_o        = summary; // [RULE_20]

endmodule : aic_ctrl

`default_nettype wire

// ===== aic_ctrl_chk.sv
/* Port checker for aic_ctrl.
   Assumes one clock and a bind onto aic_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module aic_ctrl_chk
  import aic_pkg::*;
(
  input wire logic                       clk_i,
  input wire logic                       rst_b_i,
  input wire logic                       reg_sel_i,
  input wire logic                       reg_wr_i,
  input wire logic                       reg_rd_i,
  input wire logic [5:0]                 reg_adr_i,
  input wire logic [3:0]                 reg_be_i,
  input wire logic [31:0]                reg_wdata_i,
  input wire logic [31:0]                reg_rdata_o,
  input wire logic                       reg_rvalid_o,
  input wire logic                       selftest_start_i,
  input wire logic                       master_abort_i,
  input wire logic                       target_abort_i,
  input wire logic [AIC_BIST_CODE_W-1:0] selftest_code_o,
  input wire logic                       selftest_code_wr_o,
  input wire logic                       addon_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_rd38;
    reg_sel_i && reg_rd_i && reg_adr_i == AIC_OFS_IRQ_CTRL_STATUS;
  endsequence
  sequence s_wr38;
    reg_sel_i && reg_wr_i && reg_adr_i == AIC_OFS_IRQ_CTRL_STATUS;
  endsequence
  a_sum_read: assert property (s_rd38 |=> reg_rvalid_o &&
    reg_rdata_o[23] == $past(addon_irq_o)) else $error("summary bit wrong");
  a_rsv_zero: assert property (
    reg_rvalid_o |-> reg_rdata_o[31:24] == 8'h0 &&
    !reg_rdata_o[22] && !reg_rdata_o[13] && reg_rdata_o[7:5] == 3'h0)
    else $error("reserved bit set");
  a_abort_irq: assert property (
    master_abort_i || target_abort_i |=> addon_irq_o)
    else $error("abort gave no irq");
  a_bist_irq: assert property (selftest_start_i |=> addon_irq_o)
    else $error("self-test gave no irq");
  a_irq_sticky: assert property (
    addon_irq_o && !(reg_sel_i && reg_wr_i) |=> addon_irq_o)
    else $error("irq dropped without write");
  a_zero_keeps: assert property (s_wr38 ##0 (reg_be_i == 4'h4 &&
    reg_wdata_i[21:16] == 6'h0 && addon_irq_o) |=> addon_irq_o)
    else $error("zero write cleared flag");
  a_code_pass: assert property (
    reg_sel_i && reg_wr_i && reg_be_i[0] &&
    reg_adr_i == AIC_OFS_GENERAL_CTRL |=> selftest_code_wr_o &&
    selftest_code_o == 4'($past(reg_wdata_i))) else $error("code not passed");
  a_code_quiet: assert property (
    selftest_code_wr_o |-> $past(reg_wr_i) &&
    $past(reg_adr_i) == AIC_OFS_GENERAL_CTRL) else $error("stray code pulse");
endmodule : aic_ctrl_chk
bind aic_ctrl aic_ctrl_chk chk_u (.clk_i, .rst_b_i, .reg_sel_i, .reg_wr_i,
  .reg_rd_i, .reg_adr_i, .reg_be_i, .reg_wdata_i, .reg_rdata_o,
  .reg_rvalid_o, .selftest_start_i, .master_abort_i, .target_abort_i,
  .selftest_code_o, .selftest_code_wr_o, .addon_irq_o);
`default_nettype wire

// ===== aic_addon_model.sv
/* Add-on local bus master for the register port.
   Assumes one clock; each access is a one-cycle strobe. */
`timescale 1ns/1ps
`default_nettype none
module aic_addon_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        rvalid_i,
  output logic             sel_o = 1'b0,
  output logic             wr_o = 1'b0,
  output logic             rd_o = 1'b0,
  output logic [5:0]       adr_o = 6'h0,
  output logic [3:0]       be_o = 4'h0,
  output logic [31:0]      wdata_o = 32'h0
);
  task automatic acc(input logic w, input logic [5:0] a, input logic [3:0] b,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {sel_o, wr_o, rd_o, adr_o, be_o, wdata_o} <= {1'b1, w, !w, a, b, d};
    @(posedge clk_i);
    {sel_o, wr_o, rd_o} <= 3'h0;
    // Released lines toggle so stale data never looks valid
    {adr_o, wdata_o} <= ~{a, d};
    #1;
    q = (w || rvalid_i === 1'b1) ? rdata_i : 'x;
  endtask : acc
endmodule : aic_addon_model
`default_nettype wire

// ===== aic_ctrl_bench.sv
/* Self-checking bench for aic_ctrl.
   Assumes aic_addon_model drives the register port. */
`timescale 1ns/1ps
`default_nettype none
module aic_ctrl_bench;
  import aic_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, reg_sel_i, reg_wr_i, reg_rd_i;
  logic [5:0] reg_adr_i;
  logic [3:0] reg_be_i, mbe = 4'h0, selftest_code_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, mbox_status_o, q;
  logic reg_rvalid_o, selftest_code_wr_o, addon_irq_o;
  logic [6:0] evt = 7'h0;
  logic [1:0] msel = 2'h0, cz = 2'h0;
  int fails = 0, cmp_count = 0, cyc = 0;
  localparam logic [5:0] A = AIC_OFS_IRQ_CTRL_STATUS;
  always #50 clk_i = ~clk_i;
  aic_addon_model partner_u (.clk_i, .rdata_i(reg_rdata_o),
    .rvalid_i(reg_rvalid_o), .sel_o(reg_sel_i), .wr_o(reg_wr_i),
    .rd_o(reg_rd_i), .adr_o(reg_adr_i), .be_o(reg_be_i),
    .wdata_o(reg_wdata_i));
  aic_ctrl dut_u (.clk_i, .rst_b_i, .reg_sel_i, .reg_adr_i, .reg_wr_i,
    .reg_rd_i, .reg_be_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
    .pci_ibox_wr_i(evt[0]), .pci_ibox_sel_i(msel), .pci_ibox_be_i(mbe),
    .pci_obox_rd_i(evt[1]), .pci_obox_sel_i(msel), .pci_obox_be_i(mbe),
    .addon_ibox_rd_i(evt[2]), .addon_ibox_sel_i(msel), .addon_ibox_be_i(mbe),
    .addon_obox_wr_i(evt[3]), .addon_obox_sel_i(msel), .addon_obox_be_i(mbe),
    .selftest_start_i(evt[4]), .master_abort_i(evt[5]),
    .target_abort_i(evt[6]), .mrd_count_zero_i(cz[0]),
    .mwr_count_zero_i(cz[1]), .mbox_status_o, .selftest_code_o,
    .selftest_code_wr_o, .addon_irq_o);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("Error %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    partner_u.acc(1'b1, a, b, d, q);
  endtask : wr
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    partner_u.acc(1'b0, a, 4'hf, 32'h0, q);
    chk(q, e);
  endtask : rdc
  task automatic pulse(input int i, input int s, input logic [3:0] b);
    @(posedge clk_i);
    evt[i] <= 1'b1;
    msel <= 2'(s);
    mbe <= b;
    @(posedge clk_i);
    evt <= 7'h0;
    mbe <= ~b;
    #1;
  endtask : pulse
  task automatic t_ctrl;
    chk(mbox_status_o | addon_irq_o, 32'h0);
    wr(A, 4'hf, 32'hffffffff);
    rdc(A, 32'h0000df1f);
    rdc(6'h20, 32'h0);
    wr(AIC_OFS_GENERAL_CTRL, 4'h1, 32'h5);
    chk({selftest_code_wr_o, selftest_code_o}, 32'h15);
    $display("t_ctrl done");
  endtask : t_ctrl
  task automatic t_mbox(input int dir);
    int ws, wy, t, c;
    for (int b = 0; b < 4; b++)
      for (int y = 0; y < 4; y++)
      begin
        ws = y % 2 ? b ^ 1 : b;
        wy = y % 2 ? y : y ^ 1;
        t = dir ? 1 : 0;
        c = dir ? 1 : 2;
        wr(A, 4'h3, dir ? 32'h1000 | b << 10 | y << 8 : 32'h10 | b << 2 | y);
        pulse(dir ? 3 : 0, b, 4'h1 << y);
        chk(addon_irq_o, 32'(!dir));
        wr(A, 4'h4, 32'h10000);
        pulse(t, ws, 4'h1 << wy);
        chk(addon_irq_o, 32'h0);
        chk(mbox_status_o, 32'h1 << (dir * 16 + b * 4 + y) |
          (dir ? 32'h0 : 32'h1 << (ws * 4 + wy)));
        pulse(c, b, 4'hf);
        pulse(c, ws, 4'hf);
        chk(mbox_status_o, 32'h0);
        chk(addon_irq_o, 32'(dir));
        wr(A, 4'h4, 32'h30000);
        chk(addon_irq_o, 32'h0);
      end
    $display("t_mbox done");
  endtask : t_mbox
  task automatic t_count;
    for (int i = 0; i < 2; i++)
    begin
      wr(A, 4'h3, 32'h0);
      @(posedge clk_i);
      cz[i] <= 1'b1;
      @(posedge clk_i);
      #1;
      chk(addon_irq_o, 32'h0);
      rdc(A, 32'h1 << (19 - i));
      wr(A, 4'h2, 32'h8000 >> i);
      chk(addon_irq_o, 32'h1);
      wr(A, 4'h4, 32'h1 << (19 - i));
      chk(addon_irq_o, 32'h0);
    end
    $display("t_count done");
  endtask : t_count
  task automatic t_src;
    for (int i = 4; i < 7; i++)
    begin
      pulse(i, 0, 4'h0);
      wr(A, 4'h4, 32'h0);
      rdc(A, 32'h804000 | 32'h1 << (i == 4 ? 20 : 21));
      wr(A, 4'h4, 32'h300000);
      chk(addon_irq_o, 32'h0);
    end
    $display("t_src done");
  endtask : t_src
  task automatic finish_test;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    // Run needs about 500 cycles
    if (cyc == 4000)
    begin
      fails++;
      finish_test();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_ctrl();
    t_mbox(0);
    t_mbox(1);
    t_count();
    t_src();
    finish_test();
  end
endmodule : aic_ctrl_bench
`default_nettype wire
